// ==== inc/mac_stats_pkg.sv ====
// Constants for the MAC statistics counter register bank.
// Assumes an AHB-Lite slave port with 32-bit data, one word per register index.
// Functional notes
// [RULE_01] Setting the TX shadow bit freezes readable TX counters; live counters continue.
// [RULE_02] TX state bit 1 reads high while the TX shadow bit is set.
// [RULE_03] TX state bit 0 is a sticky flag for any TX counter parity error.
// [RULE_04] Writing one to TX control bit 1 clears the parity flag; it self-clears.
// [RULE_05] Writing one to TX control bit 0 clears all TX counters; it self-clears.
// [RULE_06] Upper TX control bits 31:3 and TX state bits 31:2 are reserved.
// [RULE_07] Scratch word is freely read and written and resets to 0x08.
// [RULE_08] Revision word is read only; writes are ignored.
// [RULE_09] Three read-only words hold a twelve-character identifier, four characters each.
// [RULE_10] Each 64-bit counter reads as low word then high word at the next index.
// [RULE_11] Good octet counter adds the 16-bit increment on each valid strobe.
// [RULE_12] Counters wrap to zero on overflow instead of saturating.
// [RULE_13] Frame size is destination plus source address, data and four CRC bytes.
// [RULE_14] With receive counters left out, every receive counter read returns zero.
// [RULE_15] Reading any statistics register never changes its value.
// [RULE_16] RX control register has a bit clearing all receive counters together.
// [RULE_17] RX control bit 2 freezes readable RX counters until software clears it.
// [RULE_18] Software should set the RX shadow bit before reading a consistent snapshot.
// [RULE_19] Reserved words between frame-start counter and revision read zero, ignore writes.
package mac_stats_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_TX_START_LO = 12'h0836;
  localparam logic [11:0] IDX_TX_START_HI = 12'h0837;
  localparam logic [11:0] IDX_RSVD_FIRST = 12'h0838;
  localparam logic [11:0] IDX_RSVD_LAST = 12'h083F;
  localparam logic [11:0] IDX_REVISION = 12'h0840;
  localparam logic [11:0] IDX_SCRATCH = 12'h0841;
  localparam logic [11:0] IDX_IDENT0 = 12'h0842;
  localparam logic [11:0] IDX_IDENT1 = 12'h0843;
  localparam logic [11:0] IDX_IDENT2 = 12'h0844;
  localparam logic [11:0] IDX_TX_CONTROL = 12'h0845;
  localparam logic [11:0] IDX_TX_STATE = 12'h0846;
  localparam logic [11:0] IDX_INT_STATUS = 12'h0850;
  localparam logic [11:0] IDX_INT_MASK = 12'h0851;
  localparam logic [11:0] IDX_TX_OCTETS_LO = 12'h0860;
  localparam logic [11:0] IDX_TX_OCTETS_HI = 12'h0861;
  localparam logic [11:0] IDX_RX_FRAG_LO = 12'h0900;
  localparam logic [11:0] IDX_RX_FRAG_HI = 12'h0901;
  localparam logic [11:0] IDX_RX_FCS_LO = 12'h0904;
  localparam logic [11:0] IDX_RX_FCS_HI = 12'h0905;
  localparam logic [11:0] IDX_RX_64B_LO = 12'h0916;
  localparam logic [11:0] IDX_RX_64B_HI = 12'h0917;
  localparam logic [11:0] IDX_RX_CONTROL = 12'h0945;

  // Control and state bit positions
  localparam int BIT_CLEAR_ALL = 0;
  localparam int BIT_PARITY_CLEAR = 1;
  localparam int BIT_SHADOW = 2;
  localparam int BIT_PARITY_ERR = 0;
  localparam int BIT_FROZEN = 1;
  localparam int INT_PARITY = 0;
  localparam int INT_WRAP = 1;
  localparam int INT_BITS = 2;

  // Counter slots
  localparam int CNT_TX_START = 0;
  localparam int CNT_TX_OCTETS = 1;
  localparam int CNT_RX_FRAG = 2;
  localparam int CNT_RX_FCS = 3;
  localparam int CNT_RX_64B = 4;
  localparam int NUM_TX_CNT = 2;
  localparam int NUM_CNT = 5;

  // Frame size accounting
  localparam logic [16:0] ADDR_BYTES = 17'h0_0006;
  localparam logic [16:0] CRC_BYTES = 17'h0_0004;
  localparam logic [16:0] MIN_FRAME = 17'h0_0040;

  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0008;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// ==== logic/mac_statistics_counters.sv ====
// Statistics counter register bank with an AHB-Lite slave port.
// Assumes datapath strobes are synchronous to clk and each lasts one cycle per event.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module mac_statistics_counters #(
  parameter bit RX_STATS_EN = 1'b1,                    // Build receive counters
  parameter logic [31:0] REVISION = 32'h0000_0001,     // Arbitrary value
  parameter logic [31:0] IDENT0 = 32'h5354_4131,       // Arbitrary value
  parameter logic [31:0] IDENT1 = 32'h5354_4132,       // Arbitrary value
  parameter logic [31:0] IDENT2 = 32'h5354_4133,       // Arbitrary value
  parameter int LEN_W = 16                             // Receive data length width
) (
  input wire logic clk,                                // Clock, 250 MHz
  input wire logic arst_n,                             // Async reset, active low
  input wire logic hsel,                               // Slave select
  input wire logic [31:0] haddr,                       // Byte address
  input wire logic [1:0] htrans,                       // Transfer type
  input wire logic hwrite,                             // Write when high
  input wire logic [2:0] hsize,                        // Transfer size
  input wire logic [31:0] hwdata,                      // Write data
  input wire logic hready,                             // Bus ready
  output logic hreadyout,                              // Slave ready
  output logic hresp,                                  // Always OKAY
  output logic [31:0] hrdata,                          // Read data
  input wire logic txFrameStart,                       // One transmitted frame start
  input wire logic [15:0] txGoodOctetIncrement,        // Good octets to add
  input wire logic txGoodOctetIncrementStrobe,         // Increment valid
  input wire logic rxFrameDone,                        // Received frame ended
  input wire logic [LEN_W-1:0] rxDataLen,              // Data bytes of that frame
  input wire logic rxFcsError,                         // That frame had FCS error
  output logic irq                                     // Interrupt, active high
);

  localparam int INT_BITS = mac_stats_pkg::INT_BITS;

  logic addrTake;
  logic dValid;
  logic dFirst;
  logic dWrite;
  logic [11:0] dIdx;
  logic doWrite;
  logic [31:0] scratch;
  logic txShadow;
  logic txClearAll;
  logic txParityClear;
  logic txParityErr;
  logic rxShadow;
  logic rxClearAll;
  logic [INT_BITS-1:0] intStatus;
  logic [INT_BITS-1:0] intMask;
  logic [63:0] cnt [mac_stats_pkg::NUM_CNT];
  logic [63:0] snap [mac_stats_pkg::NUM_CNT];
  logic [63:0] view [mac_stats_pkg::NUM_CNT];
  logic [63:0] inc [mac_stats_pkg::NUM_CNT];
  logic par [mac_stats_pkg::NUM_CNT];
  logic [mac_stats_pkg::NUM_CNT-1:0] clr;
  logic [mac_stats_pkg::NUM_CNT-1:0] wrapHit;
  logic [mac_stats_pkg::NUM_CNT-1:0] parBad;
  logic [16:0] rxSize;
  logic parityEvent;
  logic wrapEvent;
  logic [31:0] next_hrdata;
  logic wrScratch;
  logic wrTxControl;
  logic wrRxControl;
  logic wrIntStatus;
  logic wrIntMask;
  logic rxShort;
  logic rxIsMin;

  assign hresp = 1'b0;
  // One wait state: read data is captured after any earlier write has landed
  assign hreadyout = ~dFirst;
  assign addrTake = hsel && htrans == mac_stats_pkg::HTRANS_NONSEQ && hready;
  assign doWrite = dValid && !dFirst && dWrite;
  // Write strobes per register, valid in the last data-phase cycle
  assign wrScratch = doWrite && dIdx == mac_stats_pkg::IDX_SCRATCH;
  assign wrTxControl = doWrite && dIdx == mac_stats_pkg::IDX_TX_CONTROL;
  assign wrRxControl = doWrite && dIdx == mac_stats_pkg::IDX_RX_CONTROL;
  assign wrIntStatus = doWrite && dIdx == mac_stats_pkg::IDX_INT_STATUS;
  assign wrIntMask = doWrite && dIdx == mac_stats_pkg::IDX_INT_MASK;

  // Address phase captured here; the data phase follows on later edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dValid <= 1'b0;
      dFirst <= 1'b0;
      dWrite <= 1'b0;
      dIdx <= 12'h000;
    end else if (addrTake) begin
      dValid <= 1'b1;
      dFirst <= 1'b1;
      dWrite <= hwrite;
      dIdx <= haddr[13:2];
    end else begin
      dFirst <= 1'b0;
      if (!dFirst) begin
        dValid <= 1'b0;
      end
    end
  end

  // [RULE_13] Frame size accounting
  // Destination and source address are six bytes each
  assign rxSize = 17'(rxDataLen) + mac_stats_pkg::ADDR_BYTES + mac_stats_pkg::ADDR_BYTES
                  + mac_stats_pkg::CRC_BYTES;
  assign rxShort = rxSize < mac_stats_pkg::MIN_FRAME;
  assign rxIsMin = rxSize == mac_stats_pkg::MIN_FRAME;

  always_comb begin
    inc[mac_stats_pkg::CNT_TX_START] = {63'd0, txFrameStart};
    // [RULE_11] Good octet increment
    inc[mac_stats_pkg::CNT_TX_OCTETS] = txGoodOctetIncrementStrobe
                                        ? {48'd0, txGoodOctetIncrement} : 64'd0;
    inc[mac_stats_pkg::CNT_RX_FRAG] = {63'd0, rxFrameDone && rxFcsError && rxShort};
    inc[mac_stats_pkg::CNT_RX_FCS] = {63'd0, rxFrameDone && rxFcsError};
    inc[mac_stats_pkg::CNT_RX_64B] = {63'd0, rxFrameDone && rxIsMin};
  end

  genvar g;
  generate
    for (g = 0; g < mac_stats_pkg::NUM_CNT; g++) begin : gCnt
      localparam bit IS_TX = g < mac_stats_pkg::NUM_TX_CNT;
      localparam bit BUILT = IS_TX || RX_STATS_EN;
      logic frozen;
      logic [64:0] sum;

      assign frozen = IS_TX ? txShadow : rxShadow;
      assign clr[g] = IS_TX ? txClearAll : rxClearAll;
      assign sum = {1'b0, cnt[g]} + {1'b0, inc[g]};
      // A clear in the same cycle takes precedence over a wrap
      assign wrapHit[g] = BUILT && !clr[g] && sum[64];
      // [RULE_03] Stored parity checked continuously
      assign parBad[g] = IS_TX && (^cnt[g] != par[g]);

      // [RULE_12] Wrap on overflow
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt[g] <= 64'd0;
          par[g] <= 1'b0;
        end else if (!BUILT || clr[g]) begin
          cnt[g] <= 64'd0;
          par[g] <= 1'b0;
        end else begin
          cnt[g] <= sum[63:0];
          par[g] <= ^sum[63:0];
        end
      end

      // [RULE_01] Snapshot tracks live value until frozen
      // Clear-all leaves a held snapshot untouched until release
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          snap[g] <= 64'd0;
        end else if (!frozen) begin
          snap[g] <= cnt[g];
        end
      end

      // [RULE_17] Readable value held while shadowed
      assign view[g] = !BUILT ? 64'd0 : (frozen ? snap[g] : cnt[g]);
    end
  endgenerate

  assign parityEvent = |parBad;
  assign wrapEvent = |wrapHit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scratch <= mac_stats_pkg::SCRATCH_RESET;
    end else if (wrScratch) begin
      // [RULE_07] Scratch word
      scratch <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txShadow <= 1'b0;
      txClearAll <= 1'b0;
      txParityClear <= 1'b0;
    end else if (wrTxControl) begin
      // [RULE_01] Shadow held until written back to zero
      txShadow <= hwdata[mac_stats_pkg::BIT_SHADOW];
      // [RULE_05] Clear-all pulse
      txClearAll <= hwdata[mac_stats_pkg::BIT_CLEAR_ALL];
      // [RULE_04] Parity clear pulse
      txParityClear <= hwdata[mac_stats_pkg::BIT_PARITY_CLEAR];
    end else begin
      // Self-clearing bits pulse for one cycle after the write
      txClearAll <= 1'b0;
      txParityClear <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxShadow <= 1'b0;
      rxClearAll <= 1'b0;
    end else if (wrRxControl) begin
      // [RULE_17] Receive shadow bit
      rxShadow <= hwdata[mac_stats_pkg::BIT_SHADOW];
      // [RULE_16] Receive clear-all pulse
      rxClearAll <= hwdata[mac_stats_pkg::BIT_CLEAR_ALL];
    end else begin
      rxClearAll <= 1'b0;
    end
  end

  // [RULE_03] Sticky parity flag, detection wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txParityErr <= 1'b0;
    end else if (parityEvent) begin
      txParityErr <= 1'b1;
    end else if (txParityClear) begin
      // [RULE_04] Cleared by control write
      txParityErr <= 1'b0;
    end
  end

  // Interrupt status: write one to clear, a new event wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intStatus <= '0;
    end else begin
      for (int i = 0; i < INT_BITS; i++) begin
        if ((i == mac_stats_pkg::INT_PARITY && parityEvent)
            || (i == mac_stats_pkg::INT_WRAP && wrapEvent)) begin
          intStatus[i] <= 1'b1;
        end else if (wrIntStatus && hwdata[i]) begin
          intStatus[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intMask <= '0;
    end else if (wrIntMask) begin
      intMask <= hwdata[INT_BITS-1:0];
    end
  end

  // Registered so the pin is glitch free; one cycle behind status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  // [RULE_15] Read path is a pure mux, no side effects
  always_comb begin
    next_hrdata = mac_stats_pkg::WORD_ZERO;
    case (dIdx)
      // [RULE_10] Low word at even index, high word next
      mac_stats_pkg::IDX_TX_START_LO: begin
        next_hrdata = view[mac_stats_pkg::CNT_TX_START][31:0];
      end
      mac_stats_pkg::IDX_TX_START_HI: begin
        next_hrdata = view[mac_stats_pkg::CNT_TX_START][63:32];
      end
      // [RULE_08] Read-only revision
      mac_stats_pkg::IDX_REVISION: begin
        next_hrdata = REVISION;
      end
      mac_stats_pkg::IDX_SCRATCH: begin
        next_hrdata = scratch;
      end
      // [RULE_09] Identifier string words
      mac_stats_pkg::IDX_IDENT0: begin
        next_hrdata = IDENT0;
      end
      mac_stats_pkg::IDX_IDENT1: begin
        next_hrdata = IDENT1;
      end
      mac_stats_pkg::IDX_IDENT2: begin
        next_hrdata = IDENT2;
      end
      // [RULE_06] Reserved bits read zero
      mac_stats_pkg::IDX_TX_CONTROL: begin
        next_hrdata[mac_stats_pkg::BIT_SHADOW] = txShadow;
        next_hrdata[mac_stats_pkg::BIT_PARITY_CLEAR] = txParityClear;
        next_hrdata[mac_stats_pkg::BIT_CLEAR_ALL] = txClearAll;
      end
      // [RULE_02] Frozen indication
      mac_stats_pkg::IDX_TX_STATE: begin
        next_hrdata[mac_stats_pkg::BIT_FROZEN] = txShadow;
        next_hrdata[mac_stats_pkg::BIT_PARITY_ERR] = txParityErr;
      end
      mac_stats_pkg::IDX_INT_STATUS: begin
        next_hrdata[INT_BITS-1:0] = intStatus;
      end
      mac_stats_pkg::IDX_INT_MASK: begin
        next_hrdata[INT_BITS-1:0] = intMask;
      end
      mac_stats_pkg::IDX_TX_OCTETS_LO: begin
        next_hrdata = view[mac_stats_pkg::CNT_TX_OCTETS][31:0];
      end
      mac_stats_pkg::IDX_TX_OCTETS_HI: begin
        next_hrdata = view[mac_stats_pkg::CNT_TX_OCTETS][63:32];
      end
      // [RULE_14] Receive views are zero when not built
      mac_stats_pkg::IDX_RX_FRAG_LO: begin
        next_hrdata = view[mac_stats_pkg::CNT_RX_FRAG][31:0];
      end
      mac_stats_pkg::IDX_RX_FRAG_HI: begin
        next_hrdata = view[mac_stats_pkg::CNT_RX_FRAG][63:32];
      end
      mac_stats_pkg::IDX_RX_FCS_LO: begin
        next_hrdata = view[mac_stats_pkg::CNT_RX_FCS][31:0];
      end
      mac_stats_pkg::IDX_RX_FCS_HI: begin
        next_hrdata = view[mac_stats_pkg::CNT_RX_FCS][63:32];
      end
      mac_stats_pkg::IDX_RX_64B_LO: begin
        next_hrdata = view[mac_stats_pkg::CNT_RX_64B][31:0];
      end
      mac_stats_pkg::IDX_RX_64B_HI: begin
        next_hrdata = view[mac_stats_pkg::CNT_RX_64B][63:32];
      end
      mac_stats_pkg::IDX_RX_CONTROL: begin
        next_hrdata[mac_stats_pkg::BIT_SHADOW] = rxShadow;
        next_hrdata[mac_stats_pkg::BIT_CLEAR_ALL] = rxClearAll;
      end
      // [RULE_19] Reserved block and unmapped words read zero
      default: begin
        next_hrdata = mac_stats_pkg::WORD_ZERO;
      end
    endcase
  end

  // Captured in the wait cycle so it stands until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= mac_stats_pkg::WORD_ZERO;
    end else if (dFirst && !dWrite) begin
      hrdata <= next_hrdata;
    end
  end

endmodule

// ==== bench/mac_stats_checker.sv ====
// Concurrent checks on the register bus of the statistics bank.
// Assumes a single AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/1ps
module mac_stats_checker #(
  parameter logic [31:0] REVISION = 32'h0000_0000, // Expected revision word
  parameter logic [31:0] IDENT0 = 32'h0000_0000,   // Expected first ident word
  parameter logic [31:0] IDENT1 = 32'h0000_0000,   // Expected next ident word
  parameter logic [31:0] IDENT2 = 32'h0000_0000    // Expected final ident word
) (
  input wire logic clk,            // Clock
  input wire logic arst_n,         // Reset, active low
  input wire logic hsel,           // Slave select
  input wire logic [31:0] haddr,   // Byte address
  input wire logic [1:0] htrans,   // Transfer type
  input wire logic hwrite,         // Write when high
  input wire logic [31:0] hwdata,  // Write data
  input wire logic hready,         // Bus ready
  input wire logic hreadyout,      // Slave ready
  input wire logic hresp,          // Response
  input wire logic [31:0] hrdata   // Read data
);
  logic wrPend;
  logic [11:0] wrIdx;
  logic [31:0] scratch;
  logic shadowOn;
  wire logic taken = hsel && htrans == 2'b10 && hready;
  wire logic [11:0] idx = haddr[13:2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend <= 1'b0;
      wrIdx <= 12'h000;
    end else if (taken) begin
      wrPend <= hwrite;
      wrIdx <= idx;
    end else if (hreadyout) begin
      wrPend <= 1'b0;
    end
  end

  // Mirror of the scratch word and the TX shadow bit, updated when the data phase ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scratch <= 32'h0000_0008;
      shadowOn <= 1'b0;
    end else if (wrPend && hreadyout && wrIdx == 12'h841) begin
      scratch <= hwdata;
    end else if (wrPend && hreadyout && wrIdx == 12'h845) begin
      shadowOn <= hwdata[2];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd(logic [11:0] a);
    taken && !hwrite && idx == a;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd(logic [11:0] a, logic [31:0] val);
    s_rd(a) |-> ##2 hrdata == val;
  endproperty

  chk_resp_okay: assert property (hresp == 1'b0) else $error("response not OKAY");
  chk_wait_state: assert property (taken |=> s_wait) else $error("wait state wrong");
  chk_revision_word: assert property (p_rd(12'h840, REVISION))
    else $error("revision word wrong");
  chk_ident_first: assert property (p_rd(12'h842, IDENT0))
    else $error("first ident word wrong");
  chk_ident_next: assert property (p_rd(12'h843, IDENT1))
    else $error("next ident word wrong");
  chk_ident_final: assert property (p_rd(12'h844, IDENT2))
    else $error("final ident word wrong");
  chk_scratch_value: assert property (s_rd(12'h841) |-> ##2 hrdata == $past(scratch))
    else $error("scratch word wrong");
  chk_reserved_zero: assert property (taken && !hwrite && idx inside {[12'h838:12'h83F]}
    |-> ##2 hrdata == 32'h0000_0000) else $error("reserved word not zero");
  chk_control_rsvd: assert property (s_rd(12'h845) |-> ##2 hrdata[31:3] == 29'h0)
    else $error("control reserved bits set");
  chk_state_rsvd: assert property (s_rd(12'h846) |-> ##2 hrdata[31:2] == 30'h0)
    else $error("state reserved bits set");
  chk_frozen_flag: assert property (s_rd(12'h846) |-> ##2 hrdata[1] == $past(shadowOn))
    else $error("frozen flag wrong");
endmodule

bind mac_statistics_counters mac_stats_checker #(.REVISION(REVISION), .IDENT0(IDENT0),
  .IDENT1(IDENT1), .IDENT2(IDENT2)) u_chk (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata);

// ==== bench/mac_datapath_model.sv ====
// Model of the MAC datapath that feeds the increment strobes.
// Assumes callers start a frame right after a rising clock edge.
`timescale 1ns/1ps
module mac_datapath_model (
  input wire logic clk,                       // Clock
  output logic txFrameStart,                  // Frame start pulse
  output logic [15:0] txGoodOctetIncrement,   // Good octets
  output logic txGoodOctetIncrementStrobe,    // Octets valid
  output logic rxFrameDone,                   // Frame end pulse
  output logic [15:0] rxDataLen,              // Data bytes
  output logic rxFcsError                     // Frame had FCS error
);
  initial begin
    txFrameStart = 1'b0;
    txGoodOctetIncrement = 16'h0000;
    txGoodOctetIncrementStrobe = 1'b0;
    rxFrameDone = 1'b0;
    rxDataLen = 16'h0000;
    rxFcsError = 1'b0;
  end

  task txFrame(input logic [15:0] n);
    @(posedge clk);
    txFrameStart <= 1'b1;
    txGoodOctetIncrement <= n;
    txGoodOctetIncrementStrobe <= 1'b1;
    @(posedge clk);
    txFrameStart <= 1'b0;
    txGoodOctetIncrementStrobe <= 1'b0;
    // Stale data would hide a counter that ignores the strobe
    txGoodOctetIncrement <= ~n;
  endtask

  task rxFrame(input logic [15:0] n, input logic e);
    @(posedge clk);
    rxFrameDone <= 1'b1;
    rxDataLen <= n;
    rxFcsError <= e;
    @(posedge clk);
    rxFrameDone <= 1'b0;
    rxDataLen <= ~n;
    rxFcsError <= ~e;
  endtask
endmodule

// ==== bench/mac_statistics_counters_tb_top.sv ====
// Self-checking bench for the statistics register bank.
// Assumes one AHB-Lite master (this bench) and the datapath model.
`timescale 1ns/1ps
module mac_statistics_counters_tb_top;
  typedef struct {
    logic [11:0] idx;
    logic wr;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;
  localparam logic [31:0] REV = 32'h0000_0005; // Arbitrary value
  localparam logic [31:0] ID0 = 32'h4142_4344; // Arbitrary value
  localparam logic [31:0] ID1 = 32'h4546_4748; // Arbitrary value
  localparam logic [31:0] ID2 = 32'h494A_4B4C; // Arbitrary value
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = ZERO;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = ZERO;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata, v;
  logic txFrameStart, txGoodOctetIncrementStrobe, rxFrameDone, rxFcsError;
  logic [15:0] txGoodOctetIncrement, rxDataLen;
  int errors = 0;
  int checks = 0;
  row_t rows[13] = '{
    '{12'h841, 1'b0, ZERO, 32'h0000_0008},
    '{12'h841, 1'b1, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{12'h840, 1'b1, 32'hFFFF_FFFF, REV},
    '{12'h842, 1'b0, ZERO, ID0},
    '{12'h843, 1'b0, ZERO, ID1},
    '{12'h844, 1'b0, ZERO, ID2},
    '{12'h838, 1'b1, 32'h1234_5678, ZERO},
    '{12'h83F, 1'b0, ZERO, ZERO},
    '{12'h845, 1'b1, 32'hFFFF_FFF8, ZERO},
    '{12'h846, 1'b1, 32'hFFFF_FFFF, ZERO},
    '{12'h850, 1'b1, 32'h0000_0003, ZERO},
    '{12'h851, 1'b1, 32'h0000_0003, 32'h0000_0003},
    '{12'h870, 1'b1, 32'hFFFF_FFFF, ZERO}};

  always #2 clk = ~clk;

  mac_statistics_counters #(.REVISION(REV), .IDENT0(ID0), .IDENT1(ID1),
    .IDENT2(ID2)) dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .txFrameStart,
    .txGoodOctetIncrement, .txGoodOctetIncrementStrobe, .rxFrameDone, .rxDataLen,
    .rxFcsError, .irq);

  mac_datapath_model dp (.clk, .txFrameStart, .txGoodOctetIncrement,
    .txGoodOctetIncrementStrobe, .rxFrameDone, .rxDataLen, .rxFcsError);

  task end_sim;
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is looked at half a cycle ahead of the edge that samples it
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      errors++;
      end_sim;
    end
  endtask

  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {18'h0_0000, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready;
    @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    @(posedge clk);
    v = hrdata;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, ZERO);
    chk(v, e);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].exp);
    end
    dp.txFrame(16'hFFFF);
    dp.txFrame(16'h0040);
    dp.txFrame(16'h0001);
    rd(12'h860, 32'h0001_0040);
    rd(12'h860, 32'h0001_0040);
    rd(12'h861, ZERO);
    rd(12'h836, 32'h0000_0003);
    rd(12'h837, ZERO);
    wr(12'h845, 32'h0000_0004);
    dp.txFrame(16'h0010);
    rd(12'h860, 32'h0001_0040);
    rd(12'h846, 32'h0000_0002);
    wr(12'h845, ZERO);
    rd(12'h860, 32'h0001_0050);
    rd(12'h846, ZERO);
    wr(12'h845, 32'h0000_0002);
    rd(12'h846, ZERO);
    rd(12'h845, ZERO);
    wr(12'h845, 32'h0000_0001);
    rd(12'h845, ZERO);
    rd(12'h860, ZERO);
    rd(12'h836, ZERO);
    // Data lengths 48 and 47 give 64 and 63 byte frames with both addresses and CRC
    dp.rxFrame(16'd48, 1'b0);
    dp.rxFrame(16'd47, 1'b1);
    rd(12'h916, 32'h0000_0001);
    rd(12'h900, 32'h0000_0001);
    rd(12'h904, 32'h0000_0001);
    wr(12'h945, 32'h0000_0004);
    dp.rxFrame(16'd48, 1'b0);
    rd(12'h916, 32'h0000_0001);
    wr(12'h945, ZERO);
    rd(12'h916, 32'h0000_0002);
    wr(12'h945, 32'h0000_0001);
    rd(12'h916, ZERO);
    rd(12'h904, ZERO);
    chk({31'h0000_0000, irq}, ZERO);
    wr(12'h841, 32'h0000_00FF);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(12'h841, 32'h0000_0008);
    rd(12'h851, ZERO);
    end_sim;
  end
endmodule
